// [design/rdv_pkg.sv]
// shared constants of the ring detect and validate block
package rdv_pkg;
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_IRQ_CTRL = 6'h02;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h03;
    localparam logic [5:0] IDX_IRQ_FLAG = 6'h04;
    localparam logic [5:0] IDX_STATUS = 6'h05;
    localparam logic [5:0] IDX_PIN_CTRL = 6'h0e;
    localparam logic [5:0] IDX_LINE_A = 6'h10;
    localparam logic [5:0] IDX_LINE_B = 6'h11;
    localparam logic [5:0] IDX_RING_MODE = 6'h12;
    localparam logic [5:0] IDX_MAX_FREQ = 6'h16;
    localparam logic [5:0] IDX_TIMING = 6'h17;
    localparam logic [5:0] IDX_VALIDATE = 6'h18;
    localparam logic [5:0] IDX_LINE_CTRL = 6'h30;
    // bit positions
    localparam int B_IRQ_EN = 7;
    localparam int B_IRQ_POL = 6;
    localparam int B_BOTH_EDGE = 2;
    localparam int B_RING_IRQ = 7;
    localparam int B_ABOVE_POS = 6;
    localparam int B_BELOW_NEG = 5;
    localparam int B_DETECT = 2;
    localparam int B_RING_POL = 1;
    localparam int B_THR_SEL = 0;
    localparam int B_IMP_SEL = 1;
    localparam int B_THR_HI = 4;
    localparam int B_FULL_WAVE = 1;
    localparam int B_VAL_EN = 7;
    localparam int B_OFF_HOOK = 0;
    localparam int B_LINK_PD = 1;
    localparam int B_ONHOOK_MON = 2;
    localparam int B_DLY_LO = 3;
    localparam int B_RTO_LO = 3;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_LINE_CTRL = 8'h02;
    // substituted sample values
    localparam logic [15:0] SMP_NEG_FULL = 16'h8000;
    localparam logic [15:0] SMP_POS_FULL = 16'h7fff;
    localparam logic [15:0] SMP_FW_REST = 16'h04cc;
    // timing: one tick is a millisecond
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int ONESHOT_S = 5;
    localparam logic [12:0] ONESHOT_TICKS = 13'(ONESHOT_S * 1000 / TICK_MS);
    // validator time units as left shifts of the field value, plus one for confirm and end timeout only
    localparam int CONF_SHIFT = 6;
    localparam int RTO_SHIFT = 7;
    localparam int DLY_SHIFT = 8;
endpackage

// [design/rdv_sync.sv]
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module rdv_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);
    logic [2:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 3'h0;
            sync_out <= 3'h0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [design/rdv_top.sv]
// ring detect and validate top with apb registers
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - full-wave bit adds negative excursion detection
// - ring pin open-drain, active low, polarity bit
// - ring pin follows detection, doubled in full-wave
// - status bits show above/below threshold levels
// - detect status set per wave mode
// - detect status is retriggerable five second one-shot
// - off-hook forces detect status to zero
// - masked ring flag raises interrupt; host clears
// - flag on rising or both edges
// - substitute samples only linked, on-hook, unmonitored
// - half-wave samples swing between full scales
// - full-wave samples rest near plus 1228
// - validator checks crossing interval limits
// - confirm time then end timeout watch
// - indication delay must beat end timeout
// - validate enable bit; host keeps pcm clock
// - validation makes status show envelope
// - interrupt pin tracks flag with polarity
// - validated ring pin: envelope or one-shot
// - two bits choose ring threshold
// - impedance bit selects synthesized ringer impedance
// - interrupt pin gated by enable, polarity bit
module rdv_top #(
    parameter int TICK_LEN = rdv_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ring_sense_pos,
    input wire logic ring_sense_neg,
    input wire logic pcm_fsync,
    input wire logic [15:0] tx_sample_in,
    output logic [15:0] tx_sample_out,
    output logic ring_detect_pin_o,
    output logic ring_detect_pin_oe,
    output logic analog_or_irq_pin_o,
    output logic analog_or_irq_pin_oe,
    output logic ring_threshold_sel,
    output logic ring_threshold_sel_hi,
    output logic ringer_impedance_sel
);
    logic [7:0] irq_ctrl_q;
    logic [7:0] irq_mask_q;
    logic ring_irq_flag_q;
    logic [7:0] pin_ctrl_q;
    logic [7:0] line_a_q;
    logic [7:0] line_b_q;
    logic [7:0] ring_mode_q;
    logic [7:0] max_freq_q;
    logic [7:0] timing_q;
    logic [7:0] validate_q;
    logic [7:0] line_ctrl_q;
    logic [2:0] sync_v;
    logic ring_above_pos_threshold;
    logic ring_below_neg_threshold;
    logic fsync_s;
    logic fsync_d1_q;
    logic full_wave_ring_enable;
    logic ring_validate_enable;
    logic off_hook;
    logic link_power_down;
    logic onhook_monitor;
    logic det;
    logic [14:0] tick_cnt_q;
    logic tick_q;
    logic [12:0] oneshot_q;
    logic oneshot_on;
    logic ring_detect_status;
    logic rdt_d1_q;
    logic rise;
    logic fall;
    logic flag_set;
    logic wr_en;
    logic rd_en;
    logic [5:0] idx;
    logic mapped;
    logic [7:0] rd_byte;
    logic ring_pin_act;
    logic irq_act;
    logic [15:0] smp_d;
    logic substitute;

    rdv_val_if vif ();

    rdv_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({pcm_fsync, ring_sense_neg, ring_sense_pos}),
        .sync_out(sync_v)
    );

    rdv_validator u_val (
        .pclk(pclk),
        .presetn(presetn),
        .vif(vif)
    );

    assign ring_above_pos_threshold = sync_v[0];
    assign ring_below_neg_threshold = sync_v[1];
    assign fsync_s = sync_v[2];

    assign full_wave_ring_enable = ring_mode_q[rdv_pkg::B_FULL_WAVE];
    assign ring_validate_enable = validate_q[rdv_pkg::B_VAL_EN];
    assign off_hook = line_ctrl_q[rdv_pkg::B_OFF_HOOK];
    assign link_power_down = line_ctrl_q[rdv_pkg::B_LINK_PD];
    assign onhook_monitor = line_ctrl_q[rdv_pkg::B_ONHOOK_MON];

    assign det = ring_above_pos_threshold |
        (full_wave_ring_enable & ring_below_neg_threshold);

    assign vif.tick = tick_q;
    assign vif.pos = ring_above_pos_threshold;
    assign vif.neg = ring_below_neg_threshold;
    assign vif.enable = ring_validate_enable;
    assign vif.min_freq = validate_q[5:0];
    assign vif.max_freq = max_freq_q[5:0];
    assign vif.confirm = timing_q[2:0];
    assign vif.end_timeout = timing_q[rdv_pkg::B_RTO_LO +: 4];
    assign vif.delay = line_ctrl_q[rdv_pkg::B_DLY_LO +: 3];

    // millisecond time base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 15'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 15'(TICK_LEN - 1)) begin
            tick_cnt_q <= 15'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 15'h1;
            tick_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            oneshot_q <= 13'h0;
        else if (off_hook)
            oneshot_q <= 13'h0;
        else if (det)
            oneshot_q <= rdv_pkg::ONESHOT_TICKS;
        else if (tick_q && oneshot_q != 13'h0)
            oneshot_q <= oneshot_q - 13'h1;
    end

    assign oneshot_on = oneshot_q != 13'h0;

    assign ring_detect_status = !off_hook &&
        (ring_validate_enable ? vif.envelope : oneshot_on);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rdt_d1_q <= 1'b0;
        else
            rdt_d1_q <= ring_detect_status;
    end

    assign rise = ring_detect_status & ~rdt_d1_q;
    assign fall = ~ring_detect_status & rdt_d1_q;

    assign flag_set = rise | (irq_ctrl_q[rdv_pkg::B_BOTH_EDGE] & fall);

    // apb decode, one wait state
    assign idx = paddr[7:2];
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & penable & ~pwrite & ~pready;

    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            rdv_pkg::IDX_IRQ_CTRL: rd_byte = irq_ctrl_q;
            rdv_pkg::IDX_IRQ_MASK: rd_byte = irq_mask_q;
            rdv_pkg::IDX_IRQ_FLAG: rd_byte = {ring_irq_flag_q, 7'h0};
            rdv_pkg::IDX_STATUS: begin
                rd_byte[rdv_pkg::B_ABOVE_POS] = ring_above_pos_threshold;
                rd_byte[rdv_pkg::B_BELOW_NEG] = ring_below_neg_threshold;
                rd_byte[rdv_pkg::B_DETECT] = ring_detect_status;
            end
            rdv_pkg::IDX_PIN_CTRL: rd_byte = pin_ctrl_q;
            rdv_pkg::IDX_LINE_A: rd_byte = line_a_q;
            rdv_pkg::IDX_LINE_B: rd_byte = line_b_q;
            rdv_pkg::IDX_RING_MODE: rd_byte = ring_mode_q;
            rdv_pkg::IDX_MAX_FREQ: rd_byte = max_freq_q;
            rdv_pkg::IDX_TIMING: rd_byte = timing_q;
            rdv_pkg::IDX_VALIDATE: rd_byte = validate_q;
            rdv_pkg::IDX_LINE_CTRL: rd_byte = line_ctrl_q;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (rd_en)
                prdata <= {24'h0, mapped ? rd_byte : 8'h00};
        end
    end

    // writable control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ctrl_q <= rdv_pkg::RST_ZERO;
            irq_mask_q <= rdv_pkg::RST_ZERO;
            pin_ctrl_q <= rdv_pkg::RST_ZERO;
            line_a_q <= rdv_pkg::RST_ZERO;
            line_b_q <= rdv_pkg::RST_ZERO;
            ring_mode_q <= rdv_pkg::RST_ZERO;
            max_freq_q <= rdv_pkg::RST_ZERO;
            timing_q <= rdv_pkg::RST_ZERO;
            validate_q <= rdv_pkg::RST_ZERO;
            line_ctrl_q <= rdv_pkg::RST_LINE_CTRL;
        end else if (wr_en) begin
            case (idx)
                rdv_pkg::IDX_IRQ_CTRL: irq_ctrl_q <= pwdata[7:0];
                rdv_pkg::IDX_IRQ_MASK: irq_mask_q <= pwdata[7:0];
                rdv_pkg::IDX_PIN_CTRL: pin_ctrl_q <= pwdata[7:0];
                rdv_pkg::IDX_LINE_A: line_a_q <= pwdata[7:0];
                rdv_pkg::IDX_LINE_B: line_b_q <= pwdata[7:0];
                rdv_pkg::IDX_RING_MODE: ring_mode_q <= pwdata[7:0];
                rdv_pkg::IDX_MAX_FREQ: max_freq_q <= {2'h0, pwdata[5:0]};
                rdv_pkg::IDX_TIMING: timing_q <= {1'b0, pwdata[6:0]};
                rdv_pkg::IDX_VALIDATE: validate_q <= {pwdata[7], 1'b0, pwdata[5:0]};
                rdv_pkg::IDX_LINE_CTRL: line_ctrl_q <= {2'h0, pwdata[5:0]};
                default: line_ctrl_q <= line_ctrl_q;
            endcase
        end
    end

    // sticky flag, host writes zero to clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ring_irq_flag_q <= 1'b0;
        else if (flag_set)
            ring_irq_flag_q <= 1'b1;
        else if (wr_en && idx == rdv_pkg::IDX_IRQ_FLAG && !pwdata[rdv_pkg::B_RING_IRQ])
            ring_irq_flag_q <= 1'b0;
    end

    assign ring_pin_act = !ring_validate_enable ? det :
        (full_wave_ring_enable ? oneshot_on : vif.envelope);

    assign irq_act = ring_irq_flag_q & irq_mask_q[rdv_pkg::B_RING_IRQ];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_detect_pin_o <= 1'b0;
            ring_detect_pin_oe <= 1'b0;
            analog_or_irq_pin_o <= 1'b0;
            analog_or_irq_pin_oe <= 1'b0;
        end else begin
            ring_detect_pin_o <= pin_ctrl_q[rdv_pkg::B_RING_POL];
            ring_detect_pin_oe <= ring_pin_act;
            analog_or_irq_pin_o <= irq_ctrl_q[rdv_pkg::B_IRQ_POL];
            analog_or_irq_pin_oe <= irq_ctrl_q[rdv_pkg::B_IRQ_EN] & irq_act;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_threshold_sel <= 1'b0;
            ring_threshold_sel_hi <= 1'b0;
            ringer_impedance_sel <= 1'b0;
        end else begin
            ring_threshold_sel <= line_a_q[rdv_pkg::B_THR_SEL];
            ring_threshold_sel_hi <= line_b_q[rdv_pkg::B_THR_HI];
            ringer_impedance_sel <= line_a_q[rdv_pkg::B_IMP_SEL];
        end
    end

    assign substitute = !link_power_down && !off_hook && !onhook_monitor;

    always_comb begin
        smp_d = tx_sample_in;
        if (substitute) begin
            if (ring_above_pos_threshold)
                smp_d = rdv_pkg::SMP_POS_FULL;
            else if (full_wave_ring_enable && !ring_below_neg_threshold)
                smp_d = rdv_pkg::SMP_FW_REST;
            else
                smp_d = rdv_pkg::SMP_NEG_FULL;
        end
    end

    // sample loaded at each frame sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsync_d1_q <= 1'b0;
            tx_sample_out <= 16'h0;
        end else begin
            fsync_d1_q <= fsync_s;
            if (fsync_s && !fsync_d1_q)
                tx_sample_out <= smp_d;
        end
    end
endmodule

// [design/rdv_val_if.sv]
// carrier between the top and the ring validator
`timescale 1ns/10ps
interface rdv_val_if;
    logic tick;
    logic pos;
    logic neg;
    logic enable;
    logic [5:0] min_freq;
    logic [5:0] max_freq;
    logic [2:0] confirm;
    logic [3:0] end_timeout;
    logic [2:0] delay;
    logic envelope;
    modport top (output tick, pos, neg, enable, min_freq, max_freq, confirm, end_timeout,
        delay, input envelope);
    modport val (input tick, pos, neg, enable, min_freq, max_freq, confirm, end_timeout,
        delay, output envelope);
endinterface

// [design/rdv_validator.sv]
// ring frequency, duration and end validator
`timescale 1ns/10ps
module rdv_validator (
    input wire logic pclk,
    input wire logic presetn,
    rdv_val_if.val vif
);
    typedef enum logic [2:0] {
        V_IDLE = 3'b001,
        V_FREQ = 3'b010,
        V_RUN = 3'b100
    } rdv_vstate_t;

    rdv_vstate_t st_q;
    logic last_pos_q;
    logic pos_d1_q;
    logic neg_d1_q;
    logic [5:0] iv_q;
    logic [9:0] dur_q;
    logic [11:0] et_q;
    logic [10:0] dly_q;
    logic env_q;
    logic cross_p;
    logic cross_n;
    logic alt;
    logic [9:0] conf_len;
    logic [11:0] rto_len;
    logic [10:0] dly_len;

    assign cross_p = vif.pos & ~pos_d1_q;
    assign cross_n = vif.neg & ~neg_d1_q;
    assign alt = (cross_p & ~last_pos_q) | (cross_n & last_pos_q);
    assign conf_len = 10'({7'h0, vif.confirm} + 10'h1) << rdv_pkg::CONF_SHIFT;
    assign rto_len = 12'({8'h0, vif.end_timeout} + 12'h1) << rdv_pkg::RTO_SHIFT;
    assign dly_len = 11'({8'h0, vif.delay}) << rdv_pkg::DLY_SHIFT;
    assign vif.envelope = env_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_d1_q <= 1'b0;
            neg_d1_q <= 1'b0;
            last_pos_q <= 1'b0;
        end else begin
            pos_d1_q <= vif.pos;
            neg_d1_q <= vif.neg;
            if (cross_p)
                last_pos_q <= 1'b1;
            else if (cross_n)
                last_pos_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= V_IDLE;
            iv_q <= 6'h0;
            dur_q <= 10'h0;
            et_q <= 12'h0;
            dly_q <= 11'h0;
            env_q <= 1'b0;
        end else if (!vif.enable) begin
            st_q <= V_IDLE;
            env_q <= 1'b0;
        end else begin
            case (st_q)
                V_IDLE: begin
                    env_q <= 1'b0;
                    iv_q <= 6'h0;
                    dur_q <= 10'h0;
                    if (cross_p | cross_n)
                        st_q <= V_FREQ;
                end
                V_FREQ: begin
                    if (alt) begin
                        if (iv_q < vif.max_freq || iv_q > vif.min_freq)
                            st_q <= V_IDLE;
                        iv_q <= 6'h0;
                    end else if (vif.tick) begin
                        if (iv_q >= vif.min_freq)
                            st_q <= V_IDLE;
                        iv_q <= iv_q + 6'h1;
                    end
                    if (vif.tick)
                        dur_q <= dur_q + 10'h1;
                    if (dur_q >= conf_len) begin
                        st_q <= V_RUN;
                        et_q <= 12'h0;
                        dly_q <= 11'h0;
                    end
                end
                V_RUN: begin
                    if (cross_p | cross_n)
                        et_q <= 12'h0;
                    else if (vif.tick)
                        et_q <= et_q + 12'h1;
                    if (vif.tick && dly_q != 11'h7ff)
                        dly_q <= dly_q + 11'h1;
                    if (dly_q >= dly_len)
                        env_q <= 1'b1;
                    if (et_q >= rto_len) begin
                        st_q <= V_IDLE;
                        env_q <= 1'b0;
                    end
                end
                default: st_q <= V_IDLE;
            endcase
        end
    end
endmodule

// [testbench/rdv_host_model.sv]
// host side model: frame sync source and sample taker
`timescale 1ns/10ps
module rdv_host_model #(
    parameter int HALF_NS = 200
) (
    input wire logic run,
    input wire logic [15:0] tx_sample_out,
    output logic pcm_fsync,
    output logic [15:0] taken
);
    // frame clock runs while run is high, held low when stopped
    initial begin
        pcm_fsync = 1'b0;
        taken = 16'h0000;
        #7;
        forever begin
            #HALF_NS;
            pcm_fsync = run ? ~pcm_fsync : 1'b0;
        end
    end
    // sample taken at each frame start
    always @(posedge pcm_fsync) taken = tx_sample_out;
endmodule

// [testbench/rdv_top_sva.sv]
// port assertions for the ring detect and validate top
`timescale 1ns/10ps
module rdv_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ring_sense_pos,
    input wire logic ring_sense_neg,
    input wire logic pcm_fsync,
    input wire logic [15:0] tx_sample_out,
    input wire logic ring_detect_pin_oe,
    input wire logic analog_or_irq_pin_oe,
    input wire logic ringer_impedance_sel
);
    logic [3:0] fs_age_q;
    logic fs_prev_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pclk cycles since the last frame sync rise, held at 15
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_prev_q <= 1'b0;
            fs_age_q <= 4'hf;
        end else begin
            fs_prev_q <= pcm_fsync;
            if (pcm_fsync && !fs_prev_q) fs_age_q <= 4'h0;
            else if (fs_age_q != 4'hf) fs_age_q <= fs_age_q + 4'h1;
        end
    end
    a_ready_single:
        assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_ready_wait:
        assert property (psel && penable && !$past(penable) |=> pready)
            else $error("pready not one cycle after access");
    a_slverr_ready:
        assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_reset_quiet:
        assert property ($rose(presetn) |-> !pready && !ring_detect_pin_oe
            && !analog_or_irq_pin_oe) else $error("outputs active after reset");
    a_above_low:
        assert property ((!ring_sense_pos)[*6] ##1 (psel && penable && !pready && !pwrite
            && paddr == 8'h14) |=> !prdata[6]) else $error("above bit with sense low");
    a_above_high:
        assert property (ring_sense_pos[*6] ##1 (psel && penable && !pready && !pwrite
            && paddr == 8'h14) |=> prdata[6]) else $error("above bit missing");
    a_below_high:
        assert property (ring_sense_neg[*6] ##1 (psel && penable && !pready && !pwrite
            && paddr == 8'h14) |=> prdata[5]) else $error("below bit missing");
    a_imp_copy:
        assert property (psel && penable && pready && pwrite && paddr == 8'h40 |-> ##2
            ringer_impedance_sel == $past(pwdata[1], 2)) else $error("impedance not copied");
    a_sample_frame:
        assert property ($changed(tx_sample_out) |-> fs_age_q < 4'h6)
            else $error("sample changed outside frame start");
endmodule
bind rdv_top rdv_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ring_sense_pos(ring_sense_pos),
    .ring_sense_neg(ring_sense_neg), .pcm_fsync(pcm_fsync), .tx_sample_out(tx_sample_out),
    .ring_detect_pin_oe(ring_detect_pin_oe), .analog_or_irq_pin_oe(analog_or_irq_pin_oe),
    .ringer_impedance_sel(ringer_impedance_sel));

// [testbench/tb.sv]
// self-checking bench for the ring detect and validate top
`timescale 1ns/10ps
module tb;
    typedef struct {logic fw; logic pos; logic neg; logic [1:0] lvl; logic oe;
        logic [15:0] smp;} rdv_row_t;
    logic pclk, presetn, psel, penable, pwrite, ring_sense_pos, ring_sense_neg, run, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, pcm_fsync, pin_o, pin_oe, irq_o, irq_oe, thr, thr_hi, imp;
    logic [15:0] tx_sample_in, tx_sample_out, taken;
    int error_cnt, checked;
    rdv_row_t rows[6] = '{'{0, 0, 0, 2'b00, 0, 16'h8000}, '{0, 1, 0, 2'b10, 1, 16'h7fff},
        '{0, 0, 1, 2'b01, 0, 16'h8000}, '{1, 0, 0, 2'b00, 0, 16'h04cc},
        '{1, 1, 0, 2'b10, 1, 16'h7fff}, '{1, 0, 1, 2'b01, 1, 16'h8000}};
    rdv_top #(.TICK_LEN(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ring_sense_pos(ring_sense_pos),
        .ring_sense_neg(ring_sense_neg), .pcm_fsync(pcm_fsync), .tx_sample_in(tx_sample_in),
        .tx_sample_out(tx_sample_out), .ring_detect_pin_o(pin_o), .ring_detect_pin_oe(pin_oe),
        .analog_or_irq_pin_o(irq_o), .analog_or_irq_pin_oe(irq_oe), .ring_threshold_sel(thr),
        .ring_threshold_sel_hi(thr_hi), .ringer_impedance_sel(imp));
    rdv_host_model u_host (.run(run), .tx_sample_out(tx_sample_out), .pcm_fsync(pcm_fsync),
        .taken(taken));
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [5:0] idx, logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_neg(int n);
        repeat (n) @(negedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, ring_sense_pos, ring_sense_neg, err} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_sample_in = 16'h1234;
        run = 1'b1;
        error_cnt = 0;
        checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, rdv_pkg::IDX_LINE_CTRL, 8'h00);
        chk("line_ctrl", rd, 32'h02);
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("status", rd, 32'h0);
        chk("pin_oe", pin_oe, 0);
        apb(0, 6'h3f, 8'h00);
        chk("slverr", err, 1);
        apb(1, rdv_pkg::IDX_LINE_CTRL, 8'h00);
        apb(1, rdv_pkg::IDX_LINE_A, 8'h03);
        apb(1, rdv_pkg::IDX_LINE_B, 8'h10);
        wait_neg(4);
        chk("thr", {thr_hi, thr}, 2'b11);
        chk("imp", imp, 1);
        $display("done reset and config");
        foreach (rows[i]) begin
            apb(1, rdv_pkg::IDX_RING_MODE, {6'h0, rows[i].fw, 1'b0});
            ring_sense_pos <= rows[i].pos;
            ring_sense_neg <= rows[i].neg;
            wait_neg(32);
            chk("pin_oe", pin_oe, rows[i].oe);
            chk("sample", taken, rows[i].smp);
            apb(0, rdv_pkg::IDX_STATUS, 8'h00);
            chk("levels", rd[6:5], rows[i].lvl);
            chk("detect", rd[2], i > 0);
        end
        {ring_sense_pos, ring_sense_neg} <= 2'b00;
        apb(1, rdv_pkg::IDX_RING_MODE, 8'h00);
        $display("done table");
        apb(1, rdv_pkg::IDX_LINE_CTRL, 8'h01);
        wait_neg(32);
        chk("offhook sample", taken, 16'h1234);
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("detect off", rd[2], 0);
        apb(1, rdv_pkg::IDX_LINE_CTRL, 8'h00);
        apb(1, rdv_pkg::IDX_IRQ_FLAG, 8'h00);
        apb(1, rdv_pkg::IDX_IRQ_CTRL, 8'h80);
        apb(1, rdv_pkg::IDX_IRQ_MASK, 8'h80);
        wait_neg(4);
        chk("irq idle", irq_oe, 0);
        ring_sense_pos <= 1'b1;
        wait_neg(10);
        chk("pin low", {pin_oe, pin_o}, 2'b10);
        apb(1, rdv_pkg::IDX_PIN_CTRL, 8'h02);
        wait_neg(4);
        chk("pin high", {pin_oe, pin_o}, 2'b11);
        ring_sense_pos <= 1'b0;
        chk("irq low", {irq_oe, irq_o}, 2'b10);
        apb(1, rdv_pkg::IDX_IRQ_CTRL, 8'hc0);
        wait_neg(4);
        chk("irq high", {irq_oe, irq_o}, 2'b11);
        apb(1, rdv_pkg::IDX_IRQ_FLAG, 8'h00);
        wait_neg(4);
        chk("irq clear", irq_oe, 0);
        $display("done irq and pin");
        apb(1, rdv_pkg::IDX_IRQ_CTRL, 8'h84);
        ring_sense_pos <= 1'b1;
        wait_neg(10);
        ring_sense_pos <= 1'b0;
        apb(0, rdv_pkg::IDX_IRQ_FLAG, 8'h00);
        chk("retrigger flag", rd[7], 0);
        wait_neg(9700);
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("oneshot held", rd[2], 1);
        wait_neg(600);
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("oneshot end", rd[2], 0);
        apb(0, rdv_pkg::IDX_IRQ_FLAG, 8'h00);
        chk("fall flag", rd[7], 1);
        $display("done one-shot");
        apb(1, rdv_pkg::IDX_VALIDATE, 8'hbf);
        ring_sense_pos <= 1'b1;
        wait_neg(10);
        chk("val pin", pin_oe, 0);
        ring_sense_pos <= 1'b0;
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("val detect", rd[2], 0);
        apb(1, rdv_pkg::IDX_MAX_FREQ, 8'h04);
        apb(1, rdv_pkg::IDX_IRQ_FLAG, 8'h00);
        repeat (8) begin
            ring_sense_pos <= 1'b1;
            wait_neg(20);
            {ring_sense_pos, ring_sense_neg} <= 2'b01;
            wait_neg(20);
            ring_sense_neg <= 1'b0;
        end
        chk("env pin", pin_oe, 1);
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("env detect", rd[2], 1);
        apb(0, rdv_pkg::IDX_IRQ_FLAG, 8'h00);
        chk("env flag", rd[7], 1);
        wait_neg(300);
        chk("env pin off", pin_oe, 0);
        apb(0, rdv_pkg::IDX_STATUS, 8'h00);
        chk("env end", rd[2], 0);
        $display("done validation");
        close_out();
    end
endmodule
